/* File: src/sdm_ctrl.sv */
// Function
// - Power-off bit forces PGA, modulator, sensor, buffers, filter off; bandgap and Vcm follow regulator.
// - Sleep keeps bandgap, Vcm, PGA, filter on; modulator, sensor, buffers off.
// - Normal runs modulator and filter; filter-reset holds filter; start after reset pulse.
// - Temperature sensor on when either channel select picks it, normal or reset.
// - Each reference buffer follows its own enable bit in normal or reset mode.
// - Common-mode generator is on exactly when the bandgap is on.
// - Conversion-done flag set to 1 at each conversion completed with latch disabled.
// - Each conversion completed with latch disabled also sets the interrupt request flag.
// - Interrupt reaches processor only with global and converter enables both set.
// - Latch disabled: result registers overwritten by every new result.
// - Latch enabled: result held, later results discarded until disabled.
// - Reference select bit picks internal or external reference pair.
// - Result is 24-bit two's complement, sign in the top bit.
// - Results saturate at 0x7fffff and 0x800000.
// - Filter reset aborts current conversion; none starts until released.
// - Conversion-done flag only cleared by software.
// - Latch enabled: no interrupt, conversion-done flag unchanged.
// - Oversample code 000 is 16384, halving down to 128 at code 111.
`timescale 1ns/100ps
`default_nettype none
module sdm_ctrl #(
  parameter logic [2:0] TEMP_CHAN = 3'h7
) (
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire logic           mod_bit,
  output sdm_pkg::sdm_ana_t   ana,
  output sdm_pkg::sdm_mode_t  mode,
  output logic                conv_irq
);
  import sdm_pkg::*;

  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [4:0]  div_r;
  logic [6:0]  chan_r;
  logic [2:0]  pwr_r;
  logic        irqf_r;
  logic [23:0] result_r;
  logic        wr_pend_r;
  logic        rd_wait_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  sdm_ana_t    ana_r;
  logic        dec_done;
  logic [23:0] dec_result;

  // Bus decode
  wire        take     = hsel && htrans[1] && hready;
  wire [7:0]  wofs     = addr_r;
  wire        wr_c0    = wr_pend_r && (wofs == SDM_OFS_CTRL0);
  wire        wr_c1    = wr_pend_r && (wofs == SDM_OFS_CTRL1);
  wire        wr_div   = wr_pend_r && (wofs == SDM_OFS_CLKSEL);
  wire        wr_chan  = wr_pend_r && (wofs == SDM_OFS_CHAN);
  wire        wr_pwr   = wr_pend_r && (wofs == SDM_OFS_PWR);

  // Field views
  wire        poff     = ctrl0_r[SDM_C0_POFF];
  wire        sleep    = ctrl0_r[SDM_C0_SLEEP];
  wire        frst     = ctrl0_r[SDM_C0_FRST];
  wire [2:0]  osr_sel  = ctrl0_r[SDM_C0_OSR_LSB +: 3];
  wire [2:0]  chop_sel = ctrl1_r[SDM_C1_CHOP_LSB +: 3];
  wire        latch    = ctrl1_r[SDM_C1_LATCH];
  wire        eoc      = ctrl1_r[SDM_C1_EOC];
  wire [2:0]  pos_ch   = chan_r[SDM_CH_POS_LSB +: 3];
  wire [2:0]  neg_ch   = chan_r[SDM_CH_NEG_LSB +: 3];
  wire        ldo_en   = pwr_r[SDM_PW_LDO];
  wire        cie      = pwr_r[SDM_PW_CIE];
  wire        gie      = pwr_r[SDM_PW_GIE];

  // Mode decode
  wire        is_pdn   = poff;
  wire        is_sleep = !poff && sleep;
  wire        is_run   = !poff && !sleep;
  wire sdm_mode_t mode_nxt = sdm_mode_t'(is_pdn   ? SDM_MODE_PDN :
                                         is_sleep ? SDM_MODE_SLEEP :
                                         frst     ? SDM_MODE_RESET :
                                                    SDM_MODE_NORMAL);

  // Analog gating from the mode
  wire        bg_nxt   = !is_pdn || ldo_en;
  wire        temp_sel = (pos_ch == TEMP_CHAN) || (neg_ch == TEMP_CHAN);
  sdm_ana_t   ana_nxt;
  always_comb begin
    ana_nxt                = '0;
    ana_nxt.bandgap_on     = bg_nxt;
    ana_nxt.regulator_on   = ldo_en;
    ana_nxt.vcm_on         = bg_nxt;
    ana_nxt.pga_on         = !is_pdn;
    ana_nxt.modulator_on   = is_run;
    ana_nxt.temp_sensor_on = is_run && temp_sel;
    ana_nxt.neg_buf_on     = is_run && ctrl1_r[SDM_C1_NBUF];
    ana_nxt.pos_buf_on     = is_run && ctrl1_r[SDM_C1_PBUF];
    ana_nxt.filter_on      = !is_pdn;
    ana_nxt.filter_rst     = is_run && frst;
    ana_nxt.ref_external   = ctrl0_r[SDM_C0_REFSEL];
  end

  // Result capture: a new result is taken only with the latch open
  wire        take_res = dec_done && !latch;
  wire        eoc_clr  = wr_c1 && !hwdata[SDM_C1_EOC];
  wire        eoc_nxt  = take_res || (wr_c1 ? hwdata[SDM_C1_EOC] : eoc);
  wire        irq_clr  = wr_pwr && hwdata[SDM_PW_IRQF];
  wire        irq_nxt  = take_res || (irqf_r && !irq_clr);

  // Read mux
  wire [31:0] rd_mux =
    (addr_r == SDM_OFS_CTRL0)  ? {24'h0, ctrl0_r} :
    (addr_r == SDM_OFS_CTRL1)  ? {24'h0, ctrl1_r} :
    (addr_r == SDM_OFS_CLKSEL) ? {27'h0, div_r} :
    (addr_r == SDM_OFS_RESULT) ? {8'h0, result_r} :
    (addr_r == SDM_OFS_CHAN)   ? {25'h0, chan_r} :
    (addr_r == SDM_OFS_PWR)    ? {28'h0, irqf_r, pwr_r} :
    (addr_r == SDM_OFS_STATUS) ? {19'h0, mode, 11'(ana_r)} :
                                 32'h0000_0000;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_wait_r <= take && !hwrite;
      if (take) addr_r <= {haddr[7:2], 2'b00};
      if (rd_wait_r) hrdata_r <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl0_r <= SDM_C0_RST;
      div_r   <= SDM_DIV_RST;
      chan_r  <= 7'h00;
      pwr_r   <= 3'h0;
    end else begin
      if (wr_c0) ctrl0_r <= hwdata[7:0] & 8'hfd;
      if (wr_div) div_r <= hwdata[4:0];
      if (wr_chan) chan_r <= hwdata[6:0] & 7'h77;
      if (wr_pwr) pwr_r <= hwdata[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_r  <= SDM_C1_RST;
      irqf_r   <= 1'b0;
      result_r <= 24'h000000;
    end else begin
      if (wr_c1) ctrl1_r[7:2] <= hwdata[7:2];
      ctrl1_r[SDM_C1_EOC] <= eoc_nxt;
      irqf_r <= irq_nxt;
      if (take_res) result_r <= dec_result;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ana_r <= '0;
      mode  <= SDM_MODE_PDN;
    end else begin
      ana_r <= ana_nxt;
      mode  <= mode_nxt;
    end
  end

  sdm_decim u_decim (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (is_run),
    .frst     (frst),
    .osr_sel  (osr_sel),
    .chop_sel (chop_sel),
    .clk_div  (div_r),
    .mod_bit  (mod_bit),
    .done     (dec_done),
    .result   (dec_result)
  );

  assign hrdata    = hrdata_r;
  assign hreadyout = !rd_wait_r;
  assign hresp     = 1'b0;
  assign ana       = ana_r;
  assign conv_irq  = irqf_r && gie && cie;

  a_pwroff_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    poff |=> !ana.pga_on && !ana.modulator_on && !ana.temp_sensor_on
             && !ana.neg_buf_on && !ana.pos_buf_on && !ana.filter_on
             && (ana.bandgap_on == $past(ldo_en)))
    else $error("analog on in power down");

  a_sleep_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    (!poff && sleep) |=> ana.bandgap_on && ana.pga_on && ana.filter_on
                         && !ana.modulator_on && !ana.temp_sensor_on)
    else $error("sleep gating wrong");

  a_filter_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_run && frst) |=> ana.filter_rst && (mode == SDM_MODE_RESET))
    else $error("filter not held in reset");

  a_temp_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_run && temp_sel) |=> ana.temp_sensor_on)
    else $error("temperature sensor not on");

  a_vcm_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    ana.vcm_on == ana.bandgap_on) else $error("vcm not tied to bandgap");

  a_done_result: assert property (@(posedge core_clk) disable iff (!nrst)
    (dec_done && !latch) |=> eoc && irqf_r
                             && (result_r == $past(dec_result)))
    else $error("done flag and result out of step");

  a_latch_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    (latch && !wr_c1) |=> $stable(result_r))
    else $error("latched result changed");

  a_latch_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    (latch && !eoc && !wr_c1) |=> !eoc)
    else $error("done flag moved while latched");

  a_eoc_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
    (eoc && !eoc_clr) |=> eoc) else $error("done flag lost");

  a_irq_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    conv_irq |-> gie && cie && irqf_r) else $error("interrupt not gated");

  a_ref_sel: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 ana.ref_external == $past(ctrl0_r[SDM_C0_REFSEL]))
    else $error("reference pair wrong");

  a_reg_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 ana.regulator_on == $past(ldo_en))
    else $error("regulator state wrong");

  a_idle_off: assert property (@(posedge core_clk) disable iff (!nrst)
    !is_run |=> !ana.temp_sensor_on && !ana.neg_buf_on
                && !ana.pos_buf_on && !ana.modulator_on)
    else $error("run-only blocks on outside run");

  a_pdn_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    poff |=> mode == SDM_MODE_PDN)
    else $error("mode not power down");

  a_pdn_nofrst: assert property (@(posedge core_clk) disable iff (!nrst)
    poff |=> !ana.filter_rst)
    else $error("filter reset in power down");

  a_sleep_bufs: assert property (@(posedge core_clk) disable iff (!nrst)
    (!poff && sleep) |=> !ana.neg_buf_on && !ana.pos_buf_on && ana.vcm_on)
    else $error("buffers on in sleep");

  a_sleep_mode: assert property (@(posedge core_clk) disable iff (!nrst)
    (!poff && sleep) |=> mode == SDM_MODE_SLEEP)
    else $error("mode not sleep");

  a_sleep_nofrst: assert property (@(posedge core_clk) disable iff (!nrst)
    (!poff && sleep) |=> !ana.filter_rst)
    else $error("filter reset in sleep");

  a_run_mod: assert property (@(posedge core_clk) disable iff (!nrst)
    is_run |=> ana.modulator_on && ana.filter_on)
    else $error("modulator or filter off in run");

  a_run_pga: assert property (@(posedge core_clk) disable iff (!nrst)
    is_run |=> ana.pga_on && ana.bandgap_on)
    else $error("amplifier or bandgap off in run");

  a_rst_run: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_run && frst) |=> ana.modulator_on && ana.filter_on)
    else $error("blocks off in reset mode");

  a_filter_free: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_run && !frst) |=> !ana.filter_rst && (mode == SDM_MODE_NORMAL))
    else $error("filter held in normal mode");

  a_temp_off: assert property (@(posedge core_clk) disable iff (!nrst)
    (is_run && !temp_sel) |=> !ana.temp_sensor_on)
    else $error("temperature sensor on unselected");

  a_nbuf_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    is_run |=> ana.neg_buf_on == $past(ctrl1_r[SDM_C1_NBUF]))
    else $error("negative buffer wrong");

  a_pbuf_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    is_run |=> ana.pos_buf_on == $past(ctrl1_r[SDM_C1_PBUF]))
    else $error("positive buffer wrong");

  a_pdn_bg: assert property (@(posedge core_clk) disable iff (!nrst)
    (poff && !ldo_en) |=> !ana.bandgap_on && !ana.vcm_on)
    else $error("bandgap on without regulator");

  a_bg_on: assert property (@(posedge core_clk) disable iff (!nrst)
    !poff |=> ana.bandgap_on && ana.vcm_on)
    else $error("bandgap off while powered");

  a_eoc_set: assert property (@(posedge core_clk) disable iff (!nrst)
    take_res |=> eoc)
    else $error("done flag not set");

  a_irq_set: assert property (@(posedge core_clk) disable iff (!nrst)
    take_res |=> irqf_r)
    else $error("interrupt flag not set");

  a_irq_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
    (irqf_r && !irq_clr) |=> irqf_r)
    else $error("interrupt flag lost");

  a_irq_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    (irq_clr && !take_res) |=> !irqf_r)
    else $error("interrupt flag not cleared");

  a_irq_masked: assert property (@(posedge core_clk) disable iff (!nrst)
    !(gie && cie) |-> !conv_irq)
    else $error("interrupt passed while masked");

  a_irq_pass: assert property (@(posedge core_clk) disable iff (!nrst)
    (irqf_r && gie && cie) |-> conv_irq)
    else $error("enabled interrupt blocked");

  a_result_only: assert property (@(posedge core_clk) disable iff (!nrst)
    !take_res |=> $stable(result_r))
    else $error("result changed without a conversion");

  a_take_latch: assert property (@(posedge core_clk) disable iff (!nrst)
    latch |-> !take_res)
    else $error("result taken while latched");

  a_decim_idle: assert property (@(posedge core_clk) disable iff (!nrst)
    !is_run |=> !dec_done)
    else $error("conversion done while stopped");

  a_eoc_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    (eoc_clr && !take_res) |=> !eoc)
    else $error("done flag not cleared");

  a_latch_eoc: assert property (@(posedge core_clk) disable iff (!nrst)
    (latch && !wr_c1) |=> $stable(eoc))
    else $error("done flag changed while latched");

  a_latch_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    (latch && !irqf_r) |=> !irqf_r)
    else $error("interrupt flag set while latched");

endmodule : sdm_ctrl
`default_nettype wire

/* File: src/sdm_pkg.sv */
package sdm_pkg;

  // Register byte offsets
  localparam logic [7:0] SDM_OFS_CTRL0  = 8'h00;
  localparam logic [7:0] SDM_OFS_CTRL1  = 8'h04;
  localparam logic [7:0] SDM_OFS_CLKSEL = 8'h08;
  localparam logic [7:0] SDM_OFS_RESULT = 8'h0c;
  localparam logic [7:0] SDM_OFS_CHAN   = 8'h10;
  localparam logic [7:0] SDM_OFS_PWR    = 8'h14;
  localparam logic [7:0] SDM_OFS_STATUS = 8'h18;

  // conv_control_0 fields
  localparam int SDM_C0_FRST     = 7;
  localparam int SDM_C0_SLEEP    = 6;
  localparam int SDM_C0_POFF     = 5;
  localparam int SDM_C0_OSR_LSB  = 2;
  localparam int SDM_C0_REFSEL   = 0;
  localparam logic [7:0] SDM_C0_RST = 8'h20;

  // conv_control_1 fields
  localparam int SDM_C1_CHOP_LSB = 5;
  localparam int SDM_C1_NBUF     = 4;
  localparam int SDM_C1_PBUF     = 3;
  localparam int SDM_C1_LATCH    = 2;
  localparam int SDM_C1_EOC      = 1;
  localparam logic [7:0] SDM_C1_RST = 8'h00;
  localparam logic [7:0] SDM_C1_WMASK = 8'hfe;

  // Clock select, channel and power register fields
  localparam logic [4:0] SDM_DIV_RST    = 5'h00;
  localparam logic [4:0] SDM_DIV_BYPASS = 5'h1f;
  localparam int SDM_CH_POS_LSB  = 0;
  localparam int SDM_CH_NEG_LSB  = 4;
  localparam int SDM_PW_LDO      = 0;
  localparam int SDM_PW_CIE      = 1;
  localparam int SDM_PW_GIE      = 2;
  localparam int SDM_PW_IRQF     = 3;

  // Converter clock ratios
  localparam logic [4:0] SDM_ADCK_DIV30 = 5'h1d;
  localparam logic [4:0] SDM_ADCK_DIV12 = 5'h0b;

  // Result limits
  localparam logic [23:0] SDM_RES_MAX = 24'h7fffff;
  localparam logic [23:0] SDM_RES_MIN = 24'h800000;
  localparam int          SDM_RES_MSB = 23;

  // Largest log2 of the oversampling ratio (code 000)
  localparam logic [3:0]  SDM_OSR_LOG_MAX = 4'he;

  typedef enum logic [1:0] {
    SDM_MODE_PDN,
    SDM_MODE_SLEEP,
    SDM_MODE_NORMAL,
    SDM_MODE_RESET
  } sdm_mode_t;

  typedef struct packed {
    logic bandgap_on;
    logic regulator_on;
    logic vcm_on;
    logic pga_on;
    logic modulator_on;
    logic temp_sensor_on;
    logic neg_buf_on;
    logic pos_buf_on;
    logic filter_on;
    logic filter_rst;
    logic ref_external;
  } sdm_ana_t;

  // log2 of total samples per conversion: oversampling plus chop doubling
  function automatic logic [3:0] sdm_samp_log(input logic [2:0] osr,
                                             input logic       chop2);
    sdm_samp_log = SDM_OSR_LOG_MAX - {1'b0, osr} + {3'h0, chop2};
  endfunction : sdm_samp_log

  // Clamp a scaled sum to the 24-bit two's complement range
  function automatic logic [23:0] sdm_sat24(input logic signed [33:0] v);
    if (v > $signed({10'h000, SDM_RES_MAX}))
      sdm_sat24 = SDM_RES_MAX;
    else if (v < $signed({10'h3ff, SDM_RES_MIN}))
      sdm_sat24 = SDM_RES_MIN;
    else
      sdm_sat24 = v[23:0];
  endfunction : sdm_sat24

endpackage : sdm_pkg

/* File: src/sdm_decim.sv */
`timescale 1ns/100ps
`default_nettype none
module sdm_decim (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        frst,
  input  wire logic [2:0]  osr_sel,
  input  wire logic [2:0]  chop_sel,
  input  wire logic [4:0]  clk_div,
  input  wire logic        mod_bit,
  output logic             done,
  output logic [23:0]      result
);
  import sdm_pkg::*;

  logic        armed_r;
  logic [5:0]  mdiv_r;
  logic [4:0]  adiv_r;
  logic [15:0] cnt_r;
  logic signed [16:0] acc_r;
  logic        done_r;
  logic [23:0] result_r;

  wire        chop2     = ~chop_sel[2];
  wire [4:0]  adck_top  = chop_sel[1] ? SDM_ADCK_DIV12 : SDM_ADCK_DIV30;
  wire [5:0]  mdiv_top  = {clk_div, 1'b1};
  wire        mclk_tick = (clk_div == SDM_DIV_BYPASS) || (mdiv_r == mdiv_top);
  wire        samp_tick = mclk_tick && (adiv_r == adck_top);
  wire        active    = run && armed_r && !frst;
  wire [3:0]  slog      = sdm_samp_log(osr_sel, chop2);
  wire [15:0] last_cnt  = 16'((17'h1 << slog) - 17'h1);
  wire signed [16:0] acc_nxt = mod_bit ? acc_r + 17'sh1 : acc_r - 17'sh1;
  wire [4:0]  shamt     = 5'(5'd23 - {1'b0, slog});
  wire signed [33:0] scaled = 34'(acc_nxt) <<< shamt;
  wire        last_samp = active && samp_tick && (cnt_r == last_cnt);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      armed_r  <= 1'b0;
      mdiv_r   <= 6'h00;
      adiv_r   <= 5'h00;
      cnt_r    <= 16'h0000;
      acc_r    <= 17'sh0;
      done_r   <= 1'b0;
      result_r <= 24'h000000;
    end else begin
      done_r <= last_samp;
      if (!run) armed_r <= 1'b0;
      else if (frst) armed_r <= 1'b1;
      if (!active) begin
        mdiv_r <= 6'h00;
        adiv_r <= 5'h00;
        cnt_r  <= 16'h0000;
        acc_r  <= 17'sh0;
      end else begin
        mdiv_r <= mclk_tick ? 6'h00 : mdiv_r + 6'h01;
        if (mclk_tick) adiv_r <= samp_tick ? 5'h00 : adiv_r + 5'h01;
        if (samp_tick) begin
          cnt_r <= last_samp ? 16'h0000 : cnt_r + 16'h0001;
          acc_r <= last_samp ? 17'sh0 : acc_nxt;
        end
        if (last_samp) result_r <= sdm_sat24(scaled);
      end
    end
  end

  assign done   = done_r;
  assign result = result_r;

  a_no_start: assert property (@(posedge core_clk) disable iff (!nrst)
    (frst || !armed_r) |=> !done_r) else $error("conversion ran unarmed");

endmodule : sdm_decim
`default_nettype wire

/* File: test/test_sigma_delta_adc_mode_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_sigma_delta_adc_mode_control;
  import sdm_pkg::*;
  localparam logic [2:0] TCH = 3'h7;
  logic               core_clk;
  logic               nrst;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  wire logic          hready;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic               mod_bit;
  sdm_ana_t           ana;
  sdm_mode_t          mode;
  logic               conv_irq;
  int                 errors;
  int                 cmp_count;
  logic [31:0]        v;

  assign hready = hreadyout;

  sdm_ctrl #(.TEMP_CHAN(TCH)) dut (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mod_bit(mod_bit), .ana(ana), .mode(mode),
    .conv_irq(conv_irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Master samples hready and read data at the rising edge
  task automatic wait_rdy(output logic [31:0] rd);
    logic ok;
    ok = 1'b0;
    while (ok !== 1'b1) begin
      @(posedge core_clk);
      ok = hreadyout;
      rd = hrdata;
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    logic [31:0] junk;
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy(junk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(rd);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    ahb(1'b1, a, d, junk);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wr

  task automatic wait_eoc();
    int n;
    v = 32'h0;
    n = 0;
    while (v[SDM_C1_EOC] !== 1'b1 && n < 1500) begin
      ahb(1'b0, SDM_OFS_CTRL1, 32'h0, v);
      n++;
    end
    chk("eoc", {31'h0, v[SDM_C1_EOC]}, 32'h1);
  endtask : wait_eoc

  task automatic t_reset();
    ahb(1'b0, SDM_OFS_CTRL0, 32'h0, v);
    chk("ctrl0 rst", v, {24'h0, SDM_C0_RST});
    ahb(1'b0, SDM_OFS_CTRL1, 32'h0, v);
    chk("ctrl1 rst", v, {24'h0, SDM_C1_RST});
    ahb(1'b0, SDM_OFS_CLKSEL, 32'h0, v);
    chk("clksel rst", v, 32'h0);
    ahb(1'b0, 8'h1c, 32'h0, v);
    chk("unmapped", v, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hready idle", {31'h0, hreadyout}, 32'h1);
    chk("ana rst", {21'h0, ana}, 32'h0);
    chk("mode rst", {30'h0, mode}, {30'h0, SDM_MODE_PDN});
  endtask : t_reset

  task automatic t_pdn();
    wr(SDM_OFS_PWR, 32'h1);
    wr(SDM_OFS_CTRL0, 32'he0);
    chk("pdn ana", {21'h0, ana}, 32'h700);
    chk("pdn mode", {30'h0, mode}, {30'h0, SDM_MODE_PDN});
    wr(SDM_OFS_PWR, 32'h0);
    chk("pdn ldo off", {21'h0, ana}, 32'h0);
  endtask : t_pdn

  task automatic t_sleep();
    wr(SDM_OFS_PWR, 32'h1);
    wr(SDM_OFS_CLKSEL, {27'h0, SDM_DIV_BYPASS});
    wr(SDM_OFS_CTRL1, 32'hd0);
    wr(SDM_OFS_CHAN, {29'h0, TCH});
    wr(SDM_OFS_CTRL0, 32'h5d);
    chk("slp ana", {21'h0, ana} & 32'h7fe, 32'h784);
    chk("slp mode", {30'h0, mode}, {30'h0, SDM_MODE_SLEEP});
  endtask : t_sleep

  task automatic t_modes();
    wr(SDM_OFS_CTRL0, 32'h9d);
    chk("rst ana", {21'h0, ana} & 32'h7fb, 32'h7f3);
    chk("rst mode", {30'h0, mode}, {30'h0, SDM_MODE_RESET});
    wr(SDM_OFS_CTRL0, 32'h1d);
    chk("norm ana", {21'h0, ana}, 32'h7f5);
    chk("norm mode", {30'h0, mode}, {30'h0, SDM_MODE_NORMAL});
    wr(SDM_OFS_CHAN, 32'h0);
    wr(SDM_OFS_CTRL1, 32'hc8);
    chk("norm pbuf", {21'h0, ana}, 32'h7cd);
    wr(SDM_OFS_CHAN, {25'h0, TCH, 4'h0});
    chk("norm nchan", {21'h0, ana}, 32'h7ed);
  endtask : t_modes

  task automatic t_conv();
    wait_eoc();
    ahb(1'b0, SDM_OFS_RESULT, 32'h0, v);
    chk("res max", v, {8'h0, SDM_RES_MAX});
    ahb(1'b0, SDM_OFS_PWR, 32'h0, v);
    chk("irq flag", v, 32'h9);
    chk("irq none", {31'h0, conv_irq}, 32'h0);
    wr(SDM_OFS_PWR, 32'h3);
    chk("irq cie only", {31'h0, conv_irq}, 32'h0);
    wr(SDM_OFS_PWR, 32'h7);
    chk("irq both", {31'h0, conv_irq}, 32'h1);
    wr(SDM_OFS_PWR, 32'hf);
    chk("irq clr", {31'h0, conv_irq}, 32'h0);
    repeat (3200) @(posedge core_clk);
    ahb(1'b0, SDM_OFS_CTRL1, 32'h0, v);
    chk("eoc kept", v, 32'hca);
    wr(SDM_OFS_RESULT, 32'h0);
    ahb(1'b0, SDM_OFS_RESULT, 32'h0, v);
    chk("res ro", v, {8'h0, SDM_RES_MAX});
  endtask : t_conv

  task automatic t_neg();
    @(posedge core_clk);
    mod_bit <= 1'b0;
    wr(SDM_OFS_CTRL0, 32'h9d);
    wr(SDM_OFS_CTRL1, 32'hc8);
    repeat (3200) @(posedge core_clk);
    ahb(1'b0, SDM_OFS_CTRL1, 32'h0, v);
    chk("no conv in rst", v, 32'hc8);
    wr(SDM_OFS_CTRL0, 32'h1d);
    wait_eoc();
    ahb(1'b0, SDM_OFS_RESULT, 32'h0, v);
    chk("res min", v, {8'h0, SDM_RES_MIN});
    chk("irq again", {31'h0, conv_irq}, 32'h1);
  endtask : t_neg

  task automatic t_latch();
    wr(SDM_OFS_PWR, 32'hf);
    @(posedge core_clk);
    mod_bit <= 1'b1;
    wr(SDM_OFS_CTRL1, 32'hcc);
    repeat (4000) @(posedge core_clk);
    ahb(1'b0, SDM_OFS_CTRL1, 32'h0, v);
    chk("latch eoc", v, 32'hcc);
    ahb(1'b0, SDM_OFS_RESULT, 32'h0, v);
    chk("latch res", v, {8'h0, SDM_RES_MIN});
    ahb(1'b0, SDM_OFS_PWR, 32'h0, v);
    chk("latch irq", v, 32'h7);
    wr(SDM_OFS_CTRL1, 32'hc8);
    wait_eoc();
    ahb(1'b0, SDM_OFS_RESULT, 32'h0, v);
    chk("unlatch res", v, {8'h0, SDM_RES_MAX});
    wr(SDM_OFS_CTRL0, 32'h3d);
    chk("poff ana", {21'h0, ana}, 32'h701);
  endtask : t_latch

  initial begin
    errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mod_bit = 1'b1;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_pdn();
    t_sleep();
    t_modes();
    t_conv();
    t_neg();
    t_latch();
    conclude();
  end

  // Whole run is some 15000 cycles
  initial begin
    #800000;
    errors++;
    conclude();
  end
endmodule : test_sigma_delta_adc_mode_control
`default_nettype wire
